// ===== verilog/analog_value_word_pkg.sv
// Constants for the analog value word encoder: codes, band limits, scaling.
// Assumes voltage samples in microvolts and current samples in nanoamps.
// Overview of operation
// - Every measurement leaves as one 16-bit word, high byte as byte 0 and low byte as byte 1.
// - Bit 15 is the sign flag, clear for positive and set for negative, in two's complement.
// - The value carries eleven bits plus sign and the four lowest bits are driven as zero, except in the code 7FFF.
// - A value above the overdrive band gives the overflow code 7FFF.
// - A value below the underdrive band gives the underflow code 8000.
// - An invalid channel parameter set gives the code 7FFF for that channel.
// - An analog output command outside its defined range drives the output to zero.
// - Voltage ranges encode 27648 times the voltage over ten volts.
// - The 20 mA current ranges encode 27648 times the current over twenty milliamps.
// - The 4 to 20 mA range encodes 27648 times the current less 4 mA over 16 mA.
// - Codes 0 to 27648 form the nominal range, 27648 being positive full scale.
// - Overdrive stays linear up to 32511; beyond that is overflow.
// - Bipolar underdrive stays linear down to -32512; below that is underflow.
// - Unipolar underdrive stays linear down to -4864; below that is underflow.
// - Each channel takes scaling and band limits from its stored range code; its stored type code only has to match that range.
package analog_value_word_pkg;

  // ==========================================================
  // Output codes and band limits
  localparam logic [15:0] CODE_OVERFLOW = 16'h7FFF;
  localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
  localparam logic [15:0] CODE_PARAM_ERR = 16'h7FFF;
  localparam logic signed [47:0] NOMINAL_FS = 48'sd27648;
  localparam logic signed [47:0] OVERDRIVE_MAX = 48'sd32511;
  localparam logic signed [47:0] UNDER_MIN_BIP = -48'sd32512;
  localparam logic signed [47:0] UNDER_MIN_UNI = -48'sd4864;

  // ==========================================================
  // Resolution: steps of 16 codes, so full scale is 1728 steps
  localparam int STEP_SHIFT = 4;
  localparam logic signed [47:0] FS_STEPS = NOMINAL_FS >>> STEP_SHIFT;

  // ==========================================================
  // Span denominators in sample units
  localparam logic signed [47:0] VOLT_SPAN_UV = 48'sd10000000;
  localparam logic signed [47:0] CUR_SPAN_NA = 48'sd20000000;
  localparam logic signed [47:0] CUR4_SPAN_NA = 48'sd16000000;
  localparam logic signed [31:0] CUR4_OFFSET_NA = 32'sd4000000;

  // ==========================================================
  // Measuring range and type codes
  localparam logic [3:0] RANGE_OFF = 4'h0;
  localparam logic [3:0] RANGE_I_0_20 = 4'h2;
  localparam logic [3:0] RANGE_I_4_20 = 4'h3;
  localparam logic [3:0] RANGE_I_PM20 = 4'h4;
  localparam logic [3:0] RANGE_U_0_10 = 4'h8;
  localparam logic [3:0] RANGE_U_PM10 = 4'h9;
  localparam logic [3:0] TYPE_OFF = 4'h0;
  localparam logic [3:0] TYPE_VOLT = 4'h1;
  localparam logic [3:0] TYPE_CURR = 4'h2;

endpackage : analog_value_word_pkg

// ===== verilog/analog_value_word_encoder.sv
// Analog value word encoder: scales converter samples into process-image words.
// Assumes samples, parameters and output commands arrive synchronous to mclk_in.
`timescale 1ns/1ps
module analog_value_word_encoder #(
  parameter int NUM_CH = 4,
  parameter int CH_W = 2
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic param_wr_in,
  input wire logic [CH_W-1:0] param_ch_in,
  input wire logic [3:0] param_range_in,
  input wire logic [3:0] param_type_in,
  input wire logic sample_valid_in,
  input wire logic [CH_W-1:0] sample_ch_in,
  input wire logic signed [31:0] sample_in,
  input wire logic ao_valid_in,
  input wire logic signed [15:0] ao_cmd_in,
  input wire logic ao_unipolar_in,
  output logic word_valid_out,
  output logic [CH_W-1:0] word_ch_out,
  output logic [15:0] word_out,
  output logic [7:0] byte0_out,
  output logic [7:0] byte1_out,
  output logic sign_flag_out,
  output logic overflow_out,
  output logic underflow_out,
  output logic param_err_out,
  output logic [15:0] ao_code_out,
  output logic ao_zeroed_out
);
  import analog_value_word_pkg::*;

  // ==========================================================
  // Per-channel parameter store
  logic [3:0] range_q [NUM_CH];
  logic [3:0] type_q [NUM_CH];

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        range_q[i] <= RANGE_OFF;
        type_q[i] <= TYPE_OFF;
      end
    end
    else if (param_wr_in)
    begin
      range_q[param_ch_in] <= param_range_in;
      type_q[param_ch_in] <= param_type_in;
    end
  end

  // ==========================================================
  // Scaling and band classification
  logic [3:0] sel_range;
  logic [3:0] sel_type;
  logic par_ok;
  logic bipolar;
  logic signed [47:0] x_val;
  logic signed [47:0] den;
  logic signed [47:0] prod;
  logic signed [47:0] mag;
  logic signed [47:0] q_mag;
  logic signed [47:0] code;
  logic [15:0] word_d;
  logic ovf_d;
  logic unf_d;

  always_comb
  begin
    sel_range = range_q[sample_ch_in];
    sel_type = type_q[sample_ch_in];
    par_ok = 1'b1;
    bipolar = 1'b0;
    x_val = 48'(sample_in);
    den = VOLT_SPAN_UV;
    case (sel_range)
      RANGE_U_PM10:
      begin
        bipolar = 1'b1;
        par_ok = (sel_type == TYPE_VOLT);
      end
      RANGE_U_0_10:
      begin
        par_ok = (sel_type == TYPE_VOLT);
      end
      RANGE_I_PM20:
      begin
        bipolar = 1'b1;
        den = CUR_SPAN_NA;
        par_ok = (sel_type == TYPE_CURR);
      end
      RANGE_I_0_20:
      begin
        den = CUR_SPAN_NA;
        par_ok = (sel_type == TYPE_CURR);
      end
      RANGE_I_4_20:
      begin
        x_val = 48'(sample_in) - 48'(CUR4_OFFSET_NA);
        den = CUR4_SPAN_NA;
        par_ok = (sel_type == TYPE_CURR);
      end
      default:
      begin
        par_ok = 1'b0;
      end
    endcase
    // Round half away from zero to a 16-code step
    prod = x_val * FS_STEPS;
    mag = (prod < 0) ? -prod : prod;
    q_mag = (mag + (den >>> 1)) / den;
    code = ((prod < 0) ? -q_mag : q_mag) <<< STEP_SHIFT;
    ovf_d = 1'b0;
    unf_d = 1'b0;
    if (!par_ok)
    begin
      word_d = CODE_PARAM_ERR;
    end
    else if (code > OVERDRIVE_MAX)
    begin
      word_d = CODE_OVERFLOW;
      ovf_d = 1'b1;
    end
    else if (code < (bipolar ? UNDER_MIN_BIP : UNDER_MIN_UNI))
    begin
      word_d = CODE_UNDERFLOW;
      unf_d = 1'b1;
    end
    else
    begin
      word_d = code[15:0];
    end
  end

  // ==========================================================
  // Process-image word strobe and channel
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      word_valid_out <= 1'b0;
      word_ch_out <= '0;
    end
    else
    begin
      word_valid_out <= sample_valid_in;
      if (sample_valid_in)
      begin
        word_ch_out <= sample_ch_in;
      end
    end
  end

  // ==========================================================
  // Word and byte lanes
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      word_out <= 16'h0000;
      byte0_out <= 8'h00;
      byte1_out <= 8'h00;
      sign_flag_out <= 1'b0;
    end
    else if (sample_valid_in)
    begin
      word_out <= word_d;
      byte0_out <= word_d[15:8];
      byte1_out <= word_d[7:0];
      sign_flag_out <= word_d[15];
    end
  end

  // ==========================================================
  // Saturation and parameter flags
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      overflow_out <= 1'b0;
      underflow_out <= 1'b0;
      param_err_out <= 1'b0;
    end
    else if (sample_valid_in)
    begin
      overflow_out <= ovf_d;
      underflow_out <= unf_d;
      param_err_out <= ~par_ok;
    end
  end

  // ==========================================================
  // Analog output range guard
  logic signed [47:0] ao_ext;
  logic ao_bad;

  always_comb
  begin
    ao_ext = 48'(ao_cmd_in);
    ao_bad = (ao_ext > OVERDRIVE_MAX) ||
             (ao_ext < (ao_unipolar_in ? UNDER_MIN_UNI : UNDER_MIN_BIP));
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ao_code_out <= 16'h0000;
    end
    else if (ao_valid_in)
    begin
      ao_code_out <= ao_bad ? 16'h0000 : ao_cmd_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ao_zeroed_out <= 1'b0;
    end
    else if (ao_valid_in)
    begin
      ao_zeroed_out <= ao_bad;
    end
  end

endmodule : analog_value_word_encoder

// ===== verif/avw_properties.sv
// Checker for the analog value word encoder ports.
// Assumes it is bound to the encoder top module.
`timescale 1ns/1ps
module avw_props (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sample_valid_in,
  input wire logic ao_valid_in,
  input wire logic signed [15:0] ao_cmd_in,
  input wire logic ao_unipolar_in,
  input wire logic word_valid_out,
  input wire logic [15:0] word_out,
  input wire logic [7:0] byte0_out,
  input wire logic [7:0] byte1_out,
  input wire logic sign_flag_out,
  input wire logic overflow_out,
  input wire logic underflow_out,
  input wire logic param_err_out,
  input wire logic [15:0] ao_code_out,
  input wire logic ao_zeroed_out
);
  // ====
  // Word and output checks
  logic bad;
  assign bad = ao_cmd_in > 32511 || ao_cmd_in < (ao_unipolar_in ? -4864 : -32512);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_bad_cmd;
    ao_valid_in && bad;
  endsequence
  a_word_one_cycle: assert property (word_valid_out == $past(sample_valid_in)) else $error("word pulse");
  a_byte_order: assert property (word_valid_out |-> {byte0_out, byte1_out} == word_out) else $error("bytes");
  a_sign_bit: assert property (word_valid_out |-> sign_flag_out == word_out[15]) else $error("sign");
  a_low_bits_zero: assert property (word_valid_out && word_out != 16'h7FFF |-> word_out[3:0] == 4'h0)
    else $error("low bits");
  a_overflow_code: assert property (overflow_out |-> word_out == 16'h7FFF) else $error("overflow");
  a_underflow_code: assert property (underflow_out |-> word_out == 16'h8000) else $error("underflow");
  a_param_err_code: assert property (word_valid_out && param_err_out |-> word_out == 16'h7FFF && !overflow_out && !underflow_out)
    else $error("param error");
  a_ao_zeroed: assert property (s_bad_cmd |=> ao_code_out == 16'h0000 && ao_zeroed_out) else $error("ao zero");
  a_ao_passed: assert property (ao_valid_in && !bad |=> ao_code_out == $past(ao_cmd_in) && !ao_zeroed_out)
    else $error("ao pass");
endmodule : avw_props
bind analog_value_word_encoder avw_props props (.*);

// ===== verif/avw_host.sv
// Host model: rebuilds each process-image word from its two bytes.
// Assumes byte 0 is the high byte, taken on the valid pulse.
`timescale 1ns/1ps
module avw_host (
  input wire logic mclk_in,
  input wire logic word_valid_in,
  input wire logic [7:0] byte0_in,
  input wire logic [7:0] byte1_in,
  output logic got_out,
  output logic [15:0] host_word_out
);
  always_ff @(posedge mclk_in)
  begin
    got_out <= word_valid_in;
    if (word_valid_in)
      host_word_out <= {byte0_in, byte1_in};
  end
endmodule : avw_host

// ===== verif/analog_value_word_encoder_test.sv
// Self-checking testbench for the analog value word encoder.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
module analog_value_word_encoder_test;
  import analog_value_word_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, pw = 0, sv = 0, aov = 0, aou = 0, wv, got;
  logic [1:0] pc = 0, sc = 0;
  logic [3:0] pr = 0, pt = 0;
  logic signed [31:0] smp = 0;
  logic signed [15:0] cmd = 0;
  logic [15:0] hw, aoc, lfsr = 16'h0042;
  logic [7:0] b0, b1;
  logic [1:0] wch;
  logic zq;
  logic [3:0] rng [4], typ [4];
  logic [3:0] cr [8] = '{4'h9, 4'h8, 4'h4, 4'h3, 4'h2, 4'h0, 4'h9, 4'h8};
  logic [3:0] ct [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h0, 4'h2, 4'h1};
  int fv [6] = '{10000000, -10000000, 11800000, -12000000, 5000000, 0};
  logic signed [15:0] ac [6] = '{32511, 32512, -32512, -4864, -32513, -4865};
  logic [15:0] ax [6] = '{16'h7EFF, 16'h0000, 16'h8100, 16'hED00, 16'h0000, 16'h0000};
  logic az [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [15:0] expq [$];
  logic [1:0] chq [$];
  int fails = 0, n_checks = 0;
  analog_value_word_encoder dut (.mclk_in, .rst_n_in, .param_wr_in(pw), .param_ch_in(pc), .param_range_in(pr),
    .param_type_in(pt), .sample_valid_in(sv), .sample_ch_in(sc), .sample_in(smp), .ao_valid_in(aov),
    .ao_cmd_in(cmd), .ao_unipolar_in(aou), .word_valid_out(wv), .word_ch_out(wch), .word_out(), .byte0_out(b0),
    .byte1_out(b1), .sign_flag_out(), .overflow_out(), .underflow_out(), .param_err_out(), .ao_code_out(aoc),
    .ao_zeroed_out(zq));
  avw_host host (.mclk_in, .word_valid_in(wv), .byte0_in(b0), .byte1_in(b1), .got_out(got), .host_word_out(hw));
  always #4 mclk_in = ~mclk_in;
  // ====
  // Expected word from range, type and sample
  function automatic logic [15:0] ev(logic [3:0] r, logic [3:0] t, longint x);
    longint d, q;
    if (!(t == TYPE_VOLT && r inside {RANGE_U_0_10, RANGE_U_PM10} ||
      t == TYPE_CURR && r inside {RANGE_I_0_20, RANGE_I_4_20, RANGE_I_PM20}))
      return 16'h7FFF;
    d = t == TYPE_VOLT ? 10000000 : r == RANGE_I_4_20 ? 16000000 : 20000000;
    if (r == RANGE_I_4_20)
      x = x - 4000000;
    q = ((x < 0 ? -x : x) * 3456 + d) / (2 * d) * 16;
    if (x < 0)
      q = -q;
    if (q > 32511)
      return 16'h7FFF;
    if (q < (r inside {RANGE_U_PM10, RANGE_I_PM20} ? -32512 : -4864))
      return 16'h8000;
    return q[15:0];
  endfunction : ev
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic chk_ch(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected channel: expected %0d seen %0d", e, g);
    end
  endtask : chk_ch
  task automatic chk_ao(input logic [15:0] e, input logic ez, input logic [15:0] g, input logic gz);
    n_checks++;
    if (g !== e || gz !== ez)
    begin
      fails++;
      $display("unexpected analog output: expected %h/%b seen %h/%b", e, ez, g, gz);
    end
  endtask : chk_ao
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected word: expected %h seen %h", e, g);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(negedge mclk_in)
  begin
    if (got)
      chk(expq.pop_front(), hw);
    if (wv)
      chk_ch(chq.pop_front(), wch);
  end
  initial
  begin
    repeat (6) @(negedge mclk_in);
    rst_n_in = 1;
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        pw = 1;
        pc = c[1:0];
        pr = cr[p * 4 + c];
        pt = ct[p * 4 + c];
        rng[c] = pr;
        typ[c] = pt;
        @(negedge mclk_in);
      end
      pw = 0;
      for (int i = 0; i < 48; i++)
      begin
        lfsr = nxt(lfsr);
        sv = 1;
        sc = i[1:0];
        smp = i < 24 ? fv[i / 4] : $signed({16'h0000, lfsr}) * 400 - 13107200;
        expq.push_back(ev(rng[sc], typ[sc], smp));
        chq.push_back(sc);
        @(negedge mclk_in);
      end
      sv = 0;
    end
    $display("sample test done");
    for (int i = 0; i < 6; i++)
    begin
      aov = 1;
      cmd = ac[i];
      aou = i[0];
      @(negedge mclk_in);
      chk_ao(ax[i], az[i], aoc, zq);
    end
    aov = 0;
    $display("output test done");
    for (int k = 0; k < 20 && (expq.size() > 0 || chq.size() > 0); k++)
      @(negedge mclk_in);
    if (expq.size() > 0 || chq.size() > 0)
      fails++;
    report_and_stop();
  end
endmodule : analog_value_word_encoder_test
